// file: hw/pcg_pkg.sv
// Shared constants and types for the peripheral clock gating block
`default_nettype none
package pcg_pkg;
  // System clock and converter sample rates
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned RATE_125K_SPS = 125_000;
  localparam int unsigned RATE_250K_SPS = 250_000;
  localparam int unsigned RATE_500K_SPS = 500_000;
  localparam logic [7:0] DIV_125K = 8'(CLK_HZ / RATE_125K_SPS);
  localparam logic [7:0] DIV_250K = 8'(CLK_HZ / RATE_250K_SPS);
  localparam logic [7:0] DIV_500K = 8'(CLK_HZ / RATE_500K_SPS);

  // Sample-rate field codes
  localparam logic [1:0] RATE_CODE_125K = 2'h0;
  localparam logic [1:0] RATE_CODE_250K = 2'h1;
  localparam logic [1:0] RATE_CODE_500K = 2'h2;
  localparam logic [1:0] RATE_CODE_MAX = RATE_CODE_500K;

  // Register byte offsets
  localparam logic [11:0] OFS_ANA_RUN = 12'h100;
  localparam logic [11:0] OFS_TS_RUN = 12'h104;
  localparam logic [11:0] OFS_ANA_SLP = 12'h110;
  localparam logic [11:0] OFS_TS_SLP = 12'h114;
  localparam logic [11:0] OFS_ANA_DSL = 12'h120;
  localparam logic [11:0] OFS_TS_DSL = 12'h124;
  localparam logic [11:0] OFS_RUN_CFG = 12'h140;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h144;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h148;

  // Field positions, analog/pwm/watchdog group
  localparam int unsigned BIT_PWM = 20;
  localparam int unsigned BIT_ADC0 = 16;
  localparam int unsigned BIT_RATE_LO = 8;
  localparam int unsigned BIT_WDOG = 3;
  // Field positions, timer/serial group
  localparam int unsigned BIT_GPT2 = 18;
  localparam int unsigned BIT_GPT1 = 17;
  localparam int unsigned BIT_GPT0 = 16;
  localparam int unsigned BIT_TWI0 = 12;
  localparam int unsigned BIT_SYNC_SERIAL_0_GATE = 4;
  localparam int unsigned BIT_ASYNC_SERIAL_1_GATE = 1;
  localparam int unsigned BIT_ASYNC_SERIAL_0_GATE = 0;
  // Field positions, configuration and interrupt registers
  localparam int unsigned BIT_AUTO_GATE = 27;
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_CLAMP = 1;

  // Writable bits; everything else is reserved and reads zero
  localparam logic [31:0] ANA_WMASK = 32'h0011_0308;
  localparam logic [31:0] TS_WMASK = 32'h0007_1013;
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // Unit indices on the access-check port, equal to bit index in pcg_units_t
  localparam logic [3:0] UNIT_COUNT = 4'ha;

  typedef enum logic [1:0] {PCG_RUN, PCG_SLEEP, PCG_DEEP} pcg_mode_t;

  // Clock enables, async_serial_0_gate is bit 0 and pwm bit 9
  typedef struct packed {
    logic pwm;
    logic adc0;
    logic wdog;
    logic gpt2;
    logic gpt1;
    logic gpt0;
    logic twi0;
    logic sync_serial_0_gate;
    logic async_serial_1_gate;
    logic async_serial_0_gate;
  } pcg_units_t;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } pcg_wb_req_t;

  typedef struct packed {
    logic [31:0] ana_run;
    logic [31:0] ana_slp;
    logic [31:0] ana_dsl;
    logic [31:0] ts_run;
    logic [31:0] ts_slp;
    logic [31:0] ts_dsl;
    logic auto_gate;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    pcg_units_t units;
    logic [1:0] rate;
    logic ack;
    logic [31:0] rdat;
  } pcg_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } pcg_div_state_t;
endpackage : pcg_pkg
`default_nettype wire

// file: hw/pcg_rate_div.sv
// Converter sample tick divider, one-cycle enable at the selected rate
`default_nettype none
module pcg_rate_div (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [1:0] rate_i,
  output logic tick_o
);
  pcg_pkg::pcg_div_state_t st;
  pcg_pkg::pcg_div_state_t next_st;
  logic [7:0] lim;

  // Period per rate code; codes above the limit never reach here
  always_comb begin
    unique case (rate_i)
      pcg_pkg::RATE_CODE_500K: lim = pcg_pkg::DIV_500K;
      pcg_pkg::RATE_CODE_250K: lim = pcg_pkg::DIV_250K;
      default: lim = pcg_pkg::DIV_125K;
    endcase
  end

  // Counter stops and clears while the converter is gated off
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!en_i) begin
      next_st.cnt = 8'h00;
    end else if (st.cnt >= lim - 8'h01) begin
      next_st.cnt = 8'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;
endmodule : pcg_rate_div
`default_nettype wire

// file: hw/pcg_gating.sv
// Peripheral clock gating registers, mode selection and access fault check
`default_nettype none
module pcg_gating (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pcg_pkg::pcg_wb_req_t wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic sleep_i,
  input wire logic deep_sleep_i,
  input wire logic acc_req_i,
  input wire logic [3:0] acc_unit_i,
  output logic acc_fault_o,
  output pcg_pkg::pcg_units_t unit_en_o,
  output logic [1:0] adc_rate_o,
  output logic adc_tick_o,
  output logic irq_o
);
  pcg_pkg::pcg_state_t st;
  pcg_pkg::pcg_state_t next_st;
  pcg_pkg::pcg_mode_t mode;
  logic [31:0] ana_sel;
  logic [31:0] ts_sel;
  logic [31:0] byte_mask;
  logic [31:0] rd_val;
  logic hit;
  logic wr;
  logic clamp_evt;
  logic fault_evt;
  logic [1:0] irq_clr;

  // Merge write data into a register through byte lanes and writable bits
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] dat,
                                        input logic [31:0] bm, input logic [31:0] wm);
    merge = (old_v & ~(bm & wm)) | (dat & bm & wm);
  endfunction : merge

  // Out-of-range rate codes fall back to the fastest permitted rate
  function automatic logic [31:0] clamp_rate(input logic [31:0] v);
    logic [31:0] r;
    r = v;
    if (v[pcg_pkg::BIT_RATE_LO +: 2] > pcg_pkg::RATE_CODE_MAX) begin
      r[pcg_pkg::BIT_RATE_LO +: 2] = pcg_pkg::RATE_CODE_MAX;
    end
    clamp_rate = r;
  endfunction : clamp_rate

  // Byte-lane mask from sel
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      byte_mask[b*8 +: 8] = {8{wb_i.sel[b]}};
    end
  end

  // Power mode; deep sleep outranks sleep, and without auto gating the run set holds
  always_comb begin
    if (!st.auto_gate || (!sleep_i && !deep_sleep_i)) begin
      mode = pcg_pkg::PCG_RUN;
    end else if (deep_sleep_i) begin
      mode = pcg_pkg::PCG_DEEP;
    end else begin
      mode = pcg_pkg::PCG_SLEEP;
    end
  end

  // Active register set for the present mode; run set as the fallback value
  always_comb begin
    ana_sel = st.ana_run;
    ts_sel = st.ts_run;
    unique case (mode)
      pcg_pkg::PCG_RUN: begin
        ana_sel = st.ana_run;
        ts_sel = st.ts_run;
      end
      pcg_pkg::PCG_SLEEP: begin
        ana_sel = st.ana_slp;
        ts_sel = st.ts_slp;
      end
      pcg_pkg::PCG_DEEP: begin
        ana_sel = st.ana_dsl;
        ts_sel = st.ts_dsl;
      end
    endcase
  end

  // Read data; reserved bits are never stored, so they read zero
  always_comb begin
    unique case (wb_i.adr)
      pcg_pkg::OFS_ANA_RUN: rd_val = st.ana_run;
      pcg_pkg::OFS_TS_RUN: rd_val = st.ts_run;
      pcg_pkg::OFS_ANA_SLP: rd_val = st.ana_slp;
      pcg_pkg::OFS_TS_SLP: rd_val = st.ts_slp;
      pcg_pkg::OFS_ANA_DSL: rd_val = st.ana_dsl;
      pcg_pkg::OFS_TS_DSL: rd_val = st.ts_dsl;
      pcg_pkg::OFS_RUN_CFG: rd_val = 32'(st.auto_gate) << pcg_pkg::BIT_AUTO_GATE;
      pcg_pkg::OFS_IRQ_STAT: rd_val = {30'h0, st.irq_stat};
      pcg_pkg::OFS_IRQ_MASK: rd_val = {30'h0, st.irq_mask};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Access to a gated unit faults; ids past the unit list are not ours
  assign fault_evt = acc_req_i && (acc_unit_i < pcg_pkg::UNIT_COUNT)
                     && !st.units[acc_unit_i];
  assign acc_fault_o = fault_evt;

  assign hit = wb_i.cyc && wb_i.stb && !st.ack;
  assign wr = hit && wb_i.we;
  assign clamp_evt = wr && wb_i.sel[1] && (wb_i.dat[pcg_pkg::BIT_RATE_LO +: 2]
                     > pcg_pkg::RATE_CODE_MAX)
                     && (wb_i.adr == pcg_pkg::OFS_ANA_RUN || wb_i.adr == pcg_pkg::OFS_ANA_SLP
                     || wb_i.adr == pcg_pkg::OFS_ANA_DSL);
  assign irq_clr = (wr && wb_i.adr == pcg_pkg::OFS_IRQ_STAT && wb_i.sel[0])
                   ? wb_i.dat[1:0] : 2'h0;

  // Next state: bus slave, register writes, registered enables and flags
  always_comb begin
    next_st = st;
    next_st.ack = hit; // Single-cycle answer, dropped the cycle after
    if (hit) begin
      next_st.rdat = rd_val;
    end
    if (wr) begin
      unique case (wb_i.adr)
        pcg_pkg::OFS_ANA_RUN:
          next_st.ana_run = clamp_rate(merge(st.ana_run, wb_i.dat, byte_mask,
                                             pcg_pkg::ANA_WMASK));
        pcg_pkg::OFS_ANA_SLP:
          next_st.ana_slp = clamp_rate(merge(st.ana_slp, wb_i.dat, byte_mask,
                                             pcg_pkg::ANA_WMASK));
        pcg_pkg::OFS_ANA_DSL:
          next_st.ana_dsl = clamp_rate(merge(st.ana_dsl, wb_i.dat, byte_mask,
                                             pcg_pkg::ANA_WMASK));
        pcg_pkg::OFS_TS_RUN:
          next_st.ts_run = merge(st.ts_run, wb_i.dat, byte_mask, pcg_pkg::TS_WMASK);
        pcg_pkg::OFS_TS_SLP:
          next_st.ts_slp = merge(st.ts_slp, wb_i.dat, byte_mask, pcg_pkg::TS_WMASK);
        pcg_pkg::OFS_TS_DSL:
          next_st.ts_dsl = merge(st.ts_dsl, wb_i.dat, byte_mask, pcg_pkg::TS_WMASK);
        pcg_pkg::OFS_RUN_CFG:
          if (wb_i.sel[3]) begin
            next_st.auto_gate = wb_i.dat[pcg_pkg::BIT_AUTO_GATE];
          end
        pcg_pkg::OFS_IRQ_MASK:
          if (wb_i.sel[0]) begin
            next_st.irq_mask = wb_i.dat[1:0];
          end
        default: ;
      endcase
    end
    // Set wins over a same-cycle write-one clear
    next_st.irq_stat = (st.irq_stat & ~irq_clr)
                       | {clamp_evt, fault_evt};
    // Enables registered so every consumer sees one consistent value
    next_st.units.pwm = ana_sel[pcg_pkg::BIT_PWM];
    next_st.units.adc0 = ana_sel[pcg_pkg::BIT_ADC0];
    next_st.units.wdog = ana_sel[pcg_pkg::BIT_WDOG];
    next_st.units.gpt2 = ts_sel[pcg_pkg::BIT_GPT2];
    next_st.units.gpt1 = ts_sel[pcg_pkg::BIT_GPT1];
    next_st.units.gpt0 = ts_sel[pcg_pkg::BIT_GPT0];
    next_st.units.twi0 = ts_sel[pcg_pkg::BIT_TWI0];
    next_st.units.sync_serial_0_gate = ts_sel[pcg_pkg::BIT_SYNC_SERIAL_0_GATE];
    next_st.units.async_serial_1_gate = ts_sel[pcg_pkg::BIT_ASYNC_SERIAL_1_GATE];
    next_st.units.async_serial_0_gate = ts_sel[pcg_pkg::BIT_ASYNC_SERIAL_0_GATE];
    next_st.rate = ana_sel[pcg_pkg::BIT_RATE_LO +: 2];
  end

  // All gating bits clear on reset, so every unit starts unclocked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.ana_run <= pcg_pkg::GATE_RESET;
      st.ana_slp <= pcg_pkg::GATE_RESET;
      st.ana_dsl <= pcg_pkg::GATE_RESET;
      st.ts_run <= pcg_pkg::GATE_RESET;
      st.ts_slp <= pcg_pkg::GATE_RESET;
      st.ts_dsl <= pcg_pkg::GATE_RESET;
      st.irq_stat <= pcg_pkg::IRQ_RESET;
      st.irq_mask <= pcg_pkg::IRQ_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Sample tick runs while the converter is clocked; one tick can still show in the first gated cycle
  pcg_rate_div u_rate_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(st.units.adc0),
    .rate_i(st.rate),
    .tick_o(adc_tick_o)
  );

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdat;
  assign unit_en_o = st.units;
  assign adc_rate_o = st.rate;
  assign irq_o = |(st.irq_stat & st.irq_mask);

  // Checks on the gating behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr_ts_run;
    wr && wb_i.adr == pcg_pkg::OFS_TS_RUN && (&wb_i.sel);
  endsequence

  sequence s_fault;
    acc_req_i && acc_fault_o;
  endsequence

  sequence s_fast_tick;
    adc_tick_o && st.rate == pcg_pkg::RATE_CODE_500K && unit_en_o.adc0;
  endsequence

  a_pwm_gate: assert property (
    1 |=> unit_en_o.pwm == $past(ana_sel[pcg_pkg::BIT_PWM]))
    else $error("pwm enable does not follow its gating bit");

  a_adc_gate: assert property (
    !unit_en_o.adc0 |=> !adc_tick_o)
    else $error("sample tick while converter is gated off");

  a_rate_follow: assert property (
    s_fast_tick
      |-> ##[1:50] (adc_tick_o || !unit_en_o.adc0 || st.rate != pcg_pkg::RATE_CODE_500K))
    else $error("500K tick spacing wrong");

  a_rate_limit: assert property (
    st.ana_run[9:8] <= pcg_pkg::RATE_CODE_MAX && st.ana_slp[9:8] <= pcg_pkg::RATE_CODE_MAX
    && st.ana_dsl[9:8] <= pcg_pkg::RATE_CODE_MAX)
    else $error("rate field above the maximum");

  a_wdog_gate: assert property (
    !ana_sel[pcg_pkg::BIT_WDOG] |=> !unit_en_o.wdog)
    else $error("watchdog clocked while its bit is zero");

  a_bus_fault: assert property (
    s_fault |=> st.irq_stat[pcg_pkg::IRQ_FAULT])
    else $error("fault not recorded");

  a_gated_fault: assert property (
    acc_req_i && acc_unit_i == 4'h0 && !unit_en_o.async_serial_0_gate |-> acc_fault_o)
    else $error("access to gated unit did not fault");

  a_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0)
    $fell(rst_i) |-> unit_en_o == '0 && st.ts_run == 32'h0 && st.ana_run == 32'h0)
    else $error("gating bits not clear after reset");

  a_mode_select: assert property (
    deep_sleep_i && st.auto_gate |=> unit_en_o.gpt0 == $past(st.ts_dsl[pcg_pkg::BIT_GPT0]))
    else $error("deep-sleep set not applied");

  a_run_default: assert property (
    !st.auto_gate |=> unit_en_o.async_serial_1_gate == $past(st.ts_run[pcg_pkg::BIT_ASYNC_SERIAL_1_GATE]))
    else $error("run set not applied without auto gating");

  a_timer_gate: assert property (
    s_wr_ts_run ##1 (!sleep_i && !deep_sleep_i || !st.auto_gate)
      |=> {unit_en_o.gpt2, unit_en_o.gpt1, unit_en_o.gpt0} == $past(wb_i.dat[18:16], 2))
    else $error("timer enables do not follow a run write");

  a_twi_gate: assert property (
    1 |=> unit_en_o.twi0 == $past(ts_sel[pcg_pkg::BIT_TWI0]))
    else $error("two-wire enable mismatch");

  a_serial_gate: assert property (
    1 |=> {unit_en_o.sync_serial_0_gate, unit_en_o.async_serial_1_gate, unit_en_o.async_serial_0_gate}
          == {$past(ts_sel[4]), $past(ts_sel[1]), $past(ts_sel[0])})
    else $error("serial enables mismatch");

  a_reserved_zero: assert property (
    wb_ack_o && $past(wb_i.adr) == pcg_pkg::OFS_TS_RUN |-> (wb_dat_o & ~pcg_pkg::TS_WMASK) == 0)
    else $error("reserved bits read non-zero");

  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule : pcg_gating
`default_nettype wire

// file: verification/peripheral_clock_gating_tb.sv
// Self-checking testbench for the peripheral clock gating block
`default_nettype none
module peripheral_clock_gating_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // One comparison, counted; four-state equality so an unknown never matches
  `define CHK(nm, ex, got) begin \
    tests_run++; \
    if ((got) !== (ex)) begin \
      miscompares++; \
      $display("BAD %s expected %h seen %h", nm, ex, got); \
    end \
  end

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  pcg_pkg::pcg_wb_req_t wb_req = '0;
  logic sleep_i = 1'b0;
  logic deep_sleep_i = 1'b0;
  logic acc_req_i = 1'b0;
  logic [3:0] acc_unit_i = 4'h0;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic acc_fault_o;
  pcg_pkg::pcg_units_t unit_en_o;
  logic [1:0] adc_rate_o;
  logic adc_tick_o;
  logic irq_o;
  int miscompares = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic [11:0] ofs [9] = '{pcg_pkg::OFS_ANA_RUN, pcg_pkg::OFS_TS_RUN, pcg_pkg::OFS_ANA_SLP,
    pcg_pkg::OFS_TS_SLP, pcg_pkg::OFS_ANA_DSL, pcg_pkg::OFS_TS_DSL, pcg_pkg::OFS_RUN_CFG,
    pcg_pkg::OFS_IRQ_STAT, pcg_pkg::OFS_IRQ_MASK};
  int ts_bits [7] = '{0, 1, 4, 12, 16, 17, 18};
  int ana_bits [3] = '{3, 16, 20};

  // 25 MHz system clock
  always #20 clk_i = ~clk_i;

  pcg_gating uut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_i(wb_req),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .sleep_i(sleep_i),
    .deep_sleep_i(deep_sleep_i),
    .acc_req_i(acc_req_i),
    .acc_unit_i(acc_unit_i),
    .acc_fault_o(acc_fault_o),
    .unit_en_o(unit_en_o),
    .adc_rate_o(adc_rate_o),
    .adc_tick_o(adc_tick_o),
    .irq_o(irq_o)
  );

  // Expected enables, worked out bit by bit from the two group registers
  function automatic logic [9:0] en_of(input logic [31:0] ana, input logic [31:0] ts);
    return {ana[20], ana[16], ana[3], ts[18], ts[17], ts[16], ts[12], ts[4], ts[1], ts[0]};
  endfunction : en_of

  // Classic single cycle; held until ack is sampled, then released for a cycle
  task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    `CHK("wb ack", 1'b1, wb_ack_o)
    rd = wb_dat_o;
    wb_req <= '0;
  endtask : wb_xfer

  // Let one more edge land, then look 1 ns after it
  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask : settle

  // Edges between two successive converter ticks
  task automatic tick_gap(output int gap);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (adc_tick_o !== 1'b1 && n < 1000);
    gap = n;
  endtask : tick_gap

  task automatic t_reset();
    foreach (ofs[i]) begin
      wb_xfer(1'b0, ofs[i], 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    `CHK("enables after reset", 10'h000, unit_en_o)
    `CHK("irq after reset", 1'b0, irq_o)
    // Unmapped word reads zero and swallows writes
    wb_xfer(1'b1, 12'h1fc, 32'hffff_ffff);
    wb_xfer(1'b0, 12'h1fc, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    $display("test reset done");
  endtask : t_reset

  task automatic t_fields();
    wb_xfer(1'b1, pcg_pkg::OFS_ANA_RUN, 32'hffff_ffff);
    wb_xfer(1'b0, pcg_pkg::OFS_ANA_RUN, 32'h0);
    `CHK("analog readback", 32'h0011_0208, rd)
    `CHK("clamped rate", pcg_pkg::RATE_CODE_MAX, adc_rate_o)
    wb_xfer(1'b0, pcg_pkg::OFS_IRQ_STAT, 32'h0);
    `CHK("clamp flag", 1'b1, rd[pcg_pkg::IRQ_CLAMP])
    wb_xfer(1'b1, pcg_pkg::OFS_TS_RUN, 32'hffff_ffff);
    wb_xfer(1'b0, pcg_pkg::OFS_TS_RUN, 32'h0);
    `CHK("timer serial readback", 32'h0007_1013, rd)
    // Read-modify-write that keeps the reserved bits as they were read
    wb_xfer(1'b1, pcg_pkg::OFS_TS_RUN, rd & ~32'h0000_0001);
    wb_xfer(1'b0, pcg_pkg::OFS_TS_RUN, 32'h0);
    `CHK("timer serial rmw", 32'h0007_1012, rd)
    // One bit at a time, so a swapped lane cannot hide
    wb_xfer(1'b1, pcg_pkg::OFS_ANA_RUN, 32'h0);
    foreach (ts_bits[i]) begin
      wb_xfer(1'b1, pcg_pkg::OFS_TS_RUN, 32'h1 << ts_bits[i]);
      settle();
      `CHK("timer serial enable", en_of(32'h0, 32'h1 << ts_bits[i]), unit_en_o)
    end
    wb_xfer(1'b1, pcg_pkg::OFS_TS_RUN, 32'h0);
    foreach (ana_bits[i]) begin
      wb_xfer(1'b1, pcg_pkg::OFS_ANA_RUN, 32'h1 << ana_bits[i]);
      settle();
      `CHK("analog enable", en_of(32'h1 << ana_bits[i], 32'h0), unit_en_o)
    end
    $display("test fields done");
  endtask : t_fields

  task automatic t_rate();
    int gap;
    int seen;
    int lim [3] = '{200, 100, 50};
    for (int c = 0; c < 3; c++) begin
      wb_xfer(1'b1, pcg_pkg::OFS_ANA_RUN, 32'h0001_0000 | (32'(c) << 8));
      tick_gap(gap);
      tick_gap(gap);
      `CHK("tick spacing", lim[c], gap)
      `CHK("rate code", 2'(c), adc_rate_o)
    end
    // Converter gated off: no ticks after the first gated cycle
    wb_xfer(1'b1, pcg_pkg::OFS_ANA_RUN, 32'h0000_0200);
    // A tick launched before the enable dropped may still show once
    @(posedge clk_i);
    seen = 0;
    repeat (250) begin
      @(posedge clk_i);
      if (adc_tick_o !== 1'b0) seen++;
    end
    `CHK("ticks while gated", 0, seen)
    $display("test rate done");
  endtask : t_rate

  task automatic t_fault();
    wb_xfer(1'b1, pcg_pkg::OFS_ANA_RUN, 32'h0);
    wb_xfer(1'b1, pcg_pkg::OFS_IRQ_STAT, 32'h3);
    for (int u = 0; u < 11; u++) begin
      @(posedge clk_i);
      acc_req_i <= 1'b1;
      acc_unit_i <= 4'(u);
      #1;
      `CHK("fault while gated", (u < 10) ? 1'b1 : 1'b0, acc_fault_o)
    end
    @(posedge clk_i);
    acc_req_i <= 1'b0;
    wb_xfer(1'b0, pcg_pkg::OFS_IRQ_STAT, 32'h0);
    `CHK("fault status", 1'b1, rd[pcg_pkg::IRQ_FAULT])
    `CHK("irq masked", 1'b0, irq_o)
    wb_xfer(1'b1, pcg_pkg::OFS_IRQ_MASK, 32'h1);
    settle();
    `CHK("irq unmasked", 1'b1, irq_o)
    wb_xfer(1'b1, pcg_pkg::OFS_IRQ_STAT, 32'h1);
    settle();
    `CHK("irq cleared", 1'b0, irq_o)
    // All enabled: nothing faults
    wb_xfer(1'b1, pcg_pkg::OFS_ANA_RUN, 32'h0011_0008);
    wb_xfer(1'b1, pcg_pkg::OFS_TS_RUN, 32'h0007_1013);
    settle();
    for (int u = 0; u < 10; u++) begin
      @(posedge clk_i);
      acc_req_i <= 1'b1;
      acc_unit_i <= 4'(u);
      #1;
      `CHK("fault while clocked", 1'b0, acc_fault_o)
    end
    @(posedge clk_i);
    acc_req_i <= 1'b0;
    $display("test fault done");
  endtask : t_fault

  task automatic t_modes();
    wb_xfer(1'b1, pcg_pkg::OFS_ANA_RUN, 32'h0);
    wb_xfer(1'b1, pcg_pkg::OFS_TS_RUN, 32'h10);
    wb_xfer(1'b1, pcg_pkg::OFS_TS_SLP, 32'h1);
    wb_xfer(1'b1, pcg_pkg::OFS_TS_DSL, 32'h2);
    @(posedge clk_i);
    sleep_i <= 1'b1;
    settle();
    `CHK("sleep without auto", en_of(32'h0, 32'h10), unit_en_o)
    wb_xfer(1'b1, pcg_pkg::OFS_RUN_CFG, 32'h0800_0000);
    settle();
    `CHK("sleep set", en_of(32'h0, 32'h1), unit_en_o)
    @(posedge clk_i);
    deep_sleep_i <= 1'b1;
    settle();
    `CHK("deep sleep set", en_of(32'h0, 32'h2), unit_en_o)
    @(posedge clk_i);
    sleep_i <= 1'b0;
    deep_sleep_i <= 1'b0;
    settle();
    `CHK("back to run set", en_of(32'h0, 32'h10), unit_en_o)
    // Mid-run reset clears every set again
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    `CHK("enables after second reset", 10'h000, unit_en_o)
    wb_xfer(1'b0, pcg_pkg::OFS_TS_RUN, 32'h0);
    `CHK("run set after second reset", 32'h0, rd)
    $display("test modes done");
  endtask : t_modes

  // Single exit point for both normal end and watchdog
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // Main sequence after three reset cycles
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fields();
    t_rate();
    t_fault();
    t_modes();
    summarize();
  end

  // Tests need about a thousand cycles; this is a wide margin
  initial begin
    #(40 * 20000);
    miscompares++;
    $display("BAD watchdog expected done seen hang");
    summarize();
  end

  `undef CHK
endmodule : peripheral_clock_gating_tb
`default_nettype wire
